// ==== verilog/ppo_top.sv ====
// Pulse pattern output stage: registers, group transfers and pin drive
// Summary of operation
// - inverted group drives pin low for one
// - inversion bits 7..4, zero inverts, reset one
// - non-overlap bits 3..0, reset zero, normal
// - normal mode updates only on match A
// - non-overlap mode updates on A or B
// - only enabled bits take part
// - before trigger pin follows written data
// - trigger copies enabled staged bits to output
// - non-overlap match A copies every enabled bit
// - non-overlap match B copies only zero bits
// - two-bit select picks timer channel 0..3
// - non-overlap bit one selects non-overlap mode
// - transfers happen even when pin is borrowed
module ppo_top
    import ppo_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // Register port
    input  wire ppo_bus_req_t        busReq,
    output      logic [DATA_W-1:0]   rdData,
    // Timer compare match events
    input  wire ppo_timer_evt_t      timerEvt,
    // Pins taken by another peripheral
    input  wire logic [NUM_BITS-1:0] pinBorrowed,
    // Pulse output pins
    output      logic [NUM_BITS-1:0] pulseOut,
    output      logic [NUM_BITS-1:0] pulseOutEn
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0]     pulseOutData_q;
    logic [DATA_W-1:0]     pulseOutData_d;
    logic [DATA_W-1:0]     stagedNext_q;
    logic [DATA_W-1:0]     stagedEnable_q;
    logic [MODE_W-1:0]     trigSelect_q;
    logic [MODE_W-1:0]     outputMode_q;
    logic [NUM_GROUPS-1:0] updStatus_q;
    logic [NUM_GROUPS-1:0] updStatus_d;
    logic [DATA_W-1:0]     rdData_q;
    logic [DATA_W-1:0]     rdData_d;
    logic [NUM_BITS-1:0]   pulseOut_q;
    logic [NUM_BITS-1:0]   pulseOut_d;
    logic [NUM_BITS-1:0]   pulseOutEn_q;
    logic [NUM_BITS-1:0]   pulseOutEn_d;

    // ------------------------------------------------------------------
    // Group transfer requests
    // ------------------------------------------------------------------
    logic [NUM_BITS-1:0]   loadMask;
    logic [NUM_BITS-1:0]   loadValue;
    logic [NUM_GROUPS-1:0] groupFired;
    logic [NUM_GROUPS-1:0] invertN;
    logic [NUM_GROUPS-1:0] nonOverlap;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hitReg(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] ofs
    );
        hitReg = (addr == ofs);
    endfunction : hitReg
    logic wrData;
    logic wrNext;
    logic wrEnable;
    logic wrTrig;
    logic wrMode;
    logic wrStatus;

    always_comb
    begin
        wrData   = 1'b0;
        wrNext   = 1'b0;
        wrEnable = 1'b0;
        wrTrig   = 1'b0;
        wrMode   = 1'b0;
        wrStatus = 1'b0;
        if (!busReq.wr)
        begin
            wrData = 1'b0;
        end
        else if (hitReg(busReq.addr, OFS_PULSE_OUT_DATA))
        begin
            wrData = 1'b1;
        end
        else if (hitReg(busReq.addr, OFS_STAGED_NEXT))
        begin
            wrNext = 1'b1;
        end
        else if (hitReg(busReq.addr, OFS_STAGED_ENABLE))
        begin
            wrEnable = 1'b1;
        end
        else if (hitReg(busReq.addr, OFS_TRIGGER_SELECT))
        begin
            wrTrig = 1'b1;
        end
        else if (hitReg(busReq.addr, OFS_OUTPUT_MODE))
        begin
            wrMode = 1'b1;
        end
        else if (hitReg(busReq.addr, OFS_UPDATE_STATUS))
        begin
            wrStatus = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Mode fields
    // ------------------------------------------------------------------
    assign invertN    = wrMode ? busReq.wrData[MODE_INV_LSB +: NUM_GROUPS]
                               : outputMode_q[MODE_INV_LSB +: NUM_GROUPS];
    assign nonOverlap = outputMode_q[MODE_NOV_LSB +: NUM_GROUPS];

    // ------------------------------------------------------------------
    // Groups
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++)
        begin : gen_group
            ppo_load_t grpLoad;
            ppo_group u_group (
                .trigSel      (trigSelect_q[g*SEL_W +: SEL_W]),
                .nonOverlap   (nonOverlap[g]),
                .timerEvt     (timerEvt),
                .stagedData   (stagedNext_q[g*GROUP_W +: GROUP_W]),
                .stagedEnable (stagedEnable_q[g*GROUP_W +: GROUP_W]),
                .load         (grpLoad),
                .fired        (groupFired[g])
            );
            // Group k covers bits 4k..4k+3
            assign loadMask[g*GROUP_W +: GROUP_W]  = grpLoad.mask;
            assign loadValue[g*GROUP_W +: GROUP_W] = grpLoad.value;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output data
    // ------------------------------------------------------------------
    always_comb
    begin
        pulseOutData_d = pulseOutData_q;
        // Software write sets the level before any trigger
        if (wrData)
        begin
            pulseOutData_d = busReq.wrData;
        end
        // A transfer in the same cycle wins for the bits it moves
        pulseOutData_d = (pulseOutData_d & ~loadMask)
                       | (loadValue & loadMask);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pulseOutData_q <= DATA_RST;
        end
        else
        begin
            pulseOutData_q <= pulseOutData_d;
        end
    end

    // ------------------------------------------------------------------
    // Staged next data and its enable
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stagedNext_q <= DATA_RST;
        end
        else if (wrNext)
        begin
            // Reloaded by software between triggers
            stagedNext_q <= busReq.wrData;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stagedEnable_q <= DATA_RST;
        end
        else if (wrEnable)
        begin
            stagedEnable_q <= busReq.wrData;
        end
    end

    // ------------------------------------------------------------------
    // Trigger select and mode
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            trigSelect_q <= TRIG_RST;
        end
        else if (wrTrig)
        begin
            trigSelect_q <= busReq.wrData[MODE_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            outputMode_q <= MODE_RST;
        end
        else if (wrMode)
        begin
            outputMode_q <= busReq.wrData[MODE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Update status: sticky per group, write one to clear, set wins
    // ------------------------------------------------------------------
    always_comb
    begin
        updStatus_d = updStatus_q;
        if (wrStatus)
        begin
            updStatus_d = updStatus_q & ~busReq.wrData[NUM_GROUPS-1:0];
        end
        updStatus_d = updStatus_d | groupFired;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            updStatus_q <= STATUS_RST;
        end
        else
        begin
            updStatus_q <= updStatus_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data, valid in the cycle after the strobe only
    // ------------------------------------------------------------------
    always_comb
    begin
        rdData_d = UNMAPPED_RD;
        if (!busReq.rd)
        begin
            rdData_d = UNMAPPED_RD;
        end
        else if (hitReg(busReq.addr, OFS_PULSE_OUT_DATA))
        begin
            rdData_d = pulseOutData_q;
        end
        else if (hitReg(busReq.addr, OFS_STAGED_NEXT))
        begin
            rdData_d = stagedNext_q;
        end
        else if (hitReg(busReq.addr, OFS_STAGED_ENABLE))
        begin
            rdData_d = stagedEnable_q;
        end
        else if (hitReg(busReq.addr, OFS_TRIGGER_SELECT))
        begin
            rdData_d = {{(DATA_W-MODE_W){1'b0}}, trigSelect_q};
        end
        else if (hitReg(busReq.addr, OFS_OUTPUT_MODE))
        begin
            rdData_d = {{(DATA_W-MODE_W){1'b0}}, outputMode_q};
        end
        else if (hitReg(busReq.addr, OFS_UPDATE_STATUS))
        begin
            rdData_d = {{(DATA_W-NUM_GROUPS){1'b0}}, updStatus_q};
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdData_q <= UNMAPPED_RD;
        end
        else
        begin
            rdData_q <= rdData_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    always_comb
    begin
        for (int k = 0; k < NUM_BITS; k++)
        begin
            // Inverted group: data one drives low
            pulseOut_d[k] = pulseOutData_d[k]
                          ^ ~invertN[k / GROUP_W];
            // Borrowed pins are released, transfers go on regardless
            pulseOutEn_d[k] = (wrEnable ? busReq.wrData[k]
                                        : stagedEnable_q[k])
                            & ~pinBorrowed[k];
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pulseOut_q   <= PIN_RST;
            pulseOutEn_q <= PIN_RST;
        end
        else
        begin
            pulseOut_q   <= pulseOut_d;
            pulseOutEn_q <= pulseOutEn_d;
        end
    end

    assign rdData     = rdData_q;
    assign pulseOut   = pulseOut_q;
    assign pulseOutEn = pulseOutEn_q;

endmodule : ppo_top

// ==== verilog/ppo_pkg.sv ====
// Shared constants, register map and carrier types of the pulse pattern output
package ppo_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_GROUPS = 4;
    localparam int GROUP_W    = 4;
    localparam int NUM_BITS   = NUM_GROUPS * GROUP_W;
    localparam int NUM_CHAN   = 4;
    localparam int SEL_W      = 2;
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 16;
    localparam int MODE_W     = 8;

    // ------------------------------------------------------------------
    // Register offsets (word index on the register port)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PULSE_OUT_DATA  = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STAGED_NEXT     = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_STAGED_ENABLE   = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_TRIGGER_SELECT  = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_MODE     = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_UPDATE_STATUS   = 4'h5;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int MODE_INV_LSB = 4;
    localparam int MODE_NOV_LSB = 0;

    localparam logic [DATA_W-1:0]       DATA_RST    = 16'h0000;
    localparam logic [MODE_W-1:0]       MODE_RST    = 8'hF0;
    localparam logic [MODE_W-1:0]       TRIG_RST    = 8'hFF;
    localparam logic [NUM_GROUPS-1:0]   STATUS_RST  = 4'h0;
    localparam logic [NUM_BITS-1:0]     PIN_RST     = 16'h0000;
    localparam logic [DATA_W-1:0]       UNMAPPED_RD = 16'h0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_CHAN-1:0] matchA;
        logic [NUM_CHAN-1:0] matchB;
    } ppo_timer_evt_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wr;
        logic              rd;
    } ppo_bus_req_t;

    typedef struct packed {
        logic [GROUP_W-1:0] mask;
        logic [GROUP_W-1:0] value;
    } ppo_load_t;

endpackage : ppo_pkg

// ==== verilog/ppo_group.sv ====
// Trigger selection and transfer decision for one four-bit output group
module ppo_group
    import ppo_pkg::*;
(
    // Group configuration
    input  wire logic [SEL_W-1:0]   trigSel,
    input  wire logic               nonOverlap,
    // Timer events
    input  wire ppo_timer_evt_t     timerEvt,
    // Staged data of this group
    input  wire logic [GROUP_W-1:0] stagedData,
    input  wire logic [GROUP_W-1:0] stagedEnable,
    // Transfer request
    output      ppo_load_t          load,
    output      logic               fired
);

    // ------------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------------
    logic hitA;
    logic hitB;

    always_comb
    begin
        hitA = timerEvt.matchA[trigSel];
        hitB = timerEvt.matchB[trigSel];
    end

    // ------------------------------------------------------------------
    // Transfer mask
    // ------------------------------------------------------------------
    always_comb
    begin
        load.value = stagedData;
        load.mask  = '0;
        fired      = 1'b0;
        if (hitA)
        begin
            // Match A moves every enabled bit in both modes
            load.mask = stagedEnable;
            fired     = 1'b1;
        end
        else if (hitB && nonOverlap)
        begin
            // Match B only lets zeros through
            load.mask = stagedEnable & ~stagedData;
            fired     = 1'b1;
        end
    end

endmodule : ppo_group

// ==== test/ppo_top_sva.sv ====
// Assertion checker for the pulse pattern output stage
module ppo_top_sva
    import ppo_pkg::*;
(
    input wire logic                clk,
    input wire logic                nrst,
    input wire ppo_bus_req_t        busReq,
    input wire logic [DATA_W-1:0]   rdData,
    input wire ppo_timer_evt_t      timerEvt,
    input wire logic [NUM_BITS-1:0] pinBorrowed,
    input wire logic [NUM_BITS-1:0] pulseOut,
    input wire logic [NUM_BITS-1:0] pulseOutEn
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [MODE_W-1:0]     modeQ;
    logic [MODE_W-1:0]     trigQ;
    logic [NUM_BITS-1:0]   stgQ;
    logic [NUM_BITS-1:0]   enQ;
    logic [NUM_BITS-1:0]   invMask;
    logic [NUM_BITS-1:0]   dat;
    logic [NUM_BITS-1:0]   aNext;
    logic [NUM_BITS-1:0]   bNext;
    logic [NUM_GROUPS-1:0] evA;
    logic [NUM_GROUPS-1:0] evB;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Shadow copies of the configuration registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            modeQ <= MODE_RST;
            trigQ <= TRIG_RST;
            stgQ  <= DATA_RST;
            enQ   <= DATA_RST;
        end
        else if (busReq.wr)
        begin
            if (busReq.addr == OFS_OUTPUT_MODE)
                modeQ <= busReq.wrData[7:0];
            if (busReq.addr == OFS_TRIGGER_SELECT)
                trigQ <= busReq.wrData[7:0];
            if (busReq.addr == OFS_STAGED_NEXT)
                stgQ <= busReq.wrData;
            if (busReq.addr == OFS_STAGED_ENABLE)
                enQ <= busReq.wrData;
        end
    end

    // Output data seen through the pins and the expected transfers
    always_comb
    begin
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            invMask[4*g +: 4] = {4{~modeQ[MODE_INV_LSB+g]}};
            evA[g] = timerEvt.matchA[trigQ[2*g +: 2]];
            evB[g] = timerEvt.matchB[trigQ[2*g +: 2]] & modeQ[MODE_NOV_LSB+g];
        end
        dat   = pulseOut ^ invMask;
        aNext = (stgQ & enQ) | (dat & ~enQ);
        bNext = dat & ~(enQ & ~stgQ);
    end

    a_rd_idle_zero: assert property (
        !$past(busReq.rd) |-> rdData == '0)
        else $error("read data not zero outside read slot");
    a_rd_mode_val: assert property (
        busReq.rd && busReq.addr == OFS_OUTPUT_MODE
        |=> rdData == {8'h00, $past(modeQ)})
        else $error("mode register read mismatch");
    a_rd_trig_val: assert property (
        busReq.rd && busReq.addr == OFS_TRIGGER_SELECT
        |=> rdData == {8'h00, $past(trigQ)})
        else $error("trigger select read mismatch");
    a_wr_data_pin: assert property (
        busReq.wr && busReq.addr == OFS_PULSE_OUT_DATA && timerEvt == '0
        |=> pulseOut == ($past(busReq.wrData) ^ $past(invMask)))
        else $error("pin level does not follow written data");
    a_wr_enable_pin: assert property (
        busReq.wr && busReq.addr == OFS_STAGED_ENABLE ##1 $stable(pinBorrowed)
        |-> pulseOutEn == ($past(busReq.wrData) & ~pinBorrowed))
        else $error("pin enable mismatch");

    for (genvar g = 0; g < NUM_GROUPS; g++)
    begin : grp
        a_quiet_hold: assert property (
            !busReq.wr && !evA[g] && !evB[g] |=> $stable(pulseOut[4*g +: 4]))
            else $error("group output moved without trigger");
        a_match_a_copy: assert property (
            !busReq.wr && evA[g] |=> dat[4*g +: 4] == $past(aNext[4*g +: 4]))
            else $error("match A transfer mismatch");
        a_nov_b_clear: assert property (
            !busReq.wr && !evA[g] && evB[g]
            |=> dat[4*g +: 4] == $past(bNext[4*g +: 4]))
            else $error("match B transfer mismatch");
    end

    c_nov_b: cover property (evB[0]);
    c_rd_mode: cover property (busReq.rd && busReq.addr == OFS_OUTPUT_MODE);
    c_match_a: cover property (evA[3]);
endmodule : ppo_top_sva

// ==== test/ppo_timer_model.sv ====
// Timer unit model that issues compare match pulses
module ppo_timer_model
    import ppo_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Compare match events
    output ppo_timer_evt_t evt
);
    timeunit 1ns;
    timeprecision 1ps;

    initial evt = '0;

    // One clock wide pulse on the chosen channels
    task automatic pulse(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk);
        evt <= '{matchA: a, matchB: b};
        @(posedge clk);
        evt <= '0;
    endtask : pulse
endmodule : ppo_timer_model

// ==== test/ppo_top_test.sv ====
// Self-checking testbench of the pulse pattern output stage
module ppo_top_test
    import ppo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk;
    logic                nrst;
    ppo_bus_req_t        busReq;
    logic [DATA_W-1:0]   rdData;
    ppo_timer_evt_t      timerEvt;
    logic [NUM_BITS-1:0] pinBorrowed;
    logic [NUM_BITS-1:0] pulseOut;
    logic [NUM_BITS-1:0] pulseOutEn;
    int                  errCount;
    int                  numChecks;

    ppo_top DUT (.clk(clk), .nrst(nrst), .busReq(busReq), .rdData(rdData),
                 .timerEvt(timerEvt), .pinBorrowed(pinBorrowed),
                 .pulseOut(pulseOut), .pulseOutEn(pulseOutEn));
    ppo_timer_model TMR (.clk(clk), .evt(timerEvt));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string n, input logic [15:0] e, logic [15:0] s);
        numChecks++;
        if (s !== e)
        begin
            errCount++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq <= '0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        busReq <= '{addr: a, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq <= '0;
        #1;
        chk("rdData", e, rdData);
    endtask : rd

    task automatic pin(input logic [3:0] a, b, input logic [15:0] e);
        TMR.pulse(a, b);
        #1;
        chk("pulseOut", e, pulseOut);
    endtask : pin

    task automatic t_reset;
        rd(OFS_PULSE_OUT_DATA, 16'h0000);
        rd(OFS_STAGED_NEXT, 16'h0000);
        rd(OFS_STAGED_ENABLE, 16'h0000);
        rd(OFS_TRIGGER_SELECT, 16'h00FF);
        rd(OFS_OUTPUT_MODE, 16'h00F0);
        rd(4'hF, 16'h0000);
        chk("pulseOut", 16'h0000, pulseOut);
    endtask : t_reset

    task automatic t_invert;
        wr(OFS_PULSE_OUT_DATA, 16'hA5C3);
        #1;
        chk("pulseOut", 16'hA5C3, pulseOut);
        wr(OFS_OUTPUT_MODE, 16'h0050);
        #1;
        chk("pulseOut", 16'h5533, pulseOut);
        rd(OFS_OUTPUT_MODE, 16'h0050);
        wr(OFS_OUTPUT_MODE, 16'h00F0);
    endtask : t_invert

    task automatic t_channels;
        logic [15:0] dat;
        dat = 16'h0000;
        wr(OFS_PULSE_OUT_DATA, 16'h0000);
        wr(OFS_TRIGGER_SELECT, 16'h00E4);
        wr(OFS_STAGED_ENABLE, 16'hBFFF);
        wr(OFS_STAGED_NEXT, 16'hFFFF);
        for (int c = 0; c < 4; c++)
        begin
            pin(4'h0, 4'h1 << c, dat);
            dat[4*c +: 4] = 16'hBFFF >> (4*c);
            pin(4'h1 << c, 4'h0, dat);
        end
        rd(OFS_PULSE_OUT_DATA, 16'hBFFF);
    endtask : t_channels

    task automatic t_nonoverlap;
        wr(OFS_PULSE_OUT_DATA, 16'hBFF3);
        wr(OFS_STAGED_NEXT, 16'hBFFA);
        wr(OFS_OUTPUT_MODE, 16'h00F1);
        pin(4'h0, 4'h1, 16'hBFF2);
        pin(4'h1, 4'h0, 16'hBFFA);
        wr(OFS_STAGED_NEXT, 16'hBF05);
        pin(4'h0, 4'h3, 16'hBFF0);
        pin(4'h1, 4'h0, 16'hBFF5);
        rd(OFS_UPDATE_STATUS, 16'h000F);
        wr(OFS_UPDATE_STATUS, 16'h000F);
        rd(OFS_UPDATE_STATUS, 16'h0000);
    endtask : t_nonoverlap

    task automatic t_borrow;
        @(posedge clk);
        pinBorrowed <= 16'h000F;
        wr(OFS_STAGED_NEXT, 16'hBFFA);
        pin(4'h1, 4'h0, 16'hBFFA);
        chk("pulseOutEn", 16'hBFF0, pulseOutEn);
        rd(OFS_UPDATE_STATUS, 16'h0001);
        @(posedge clk);
        pinBorrowed <= 16'h0000;
    endtask : t_borrow

    task automatic results;
        if (errCount == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    initial
    begin
        nrst = 1'b0;
        busReq = '0;
        pinBorrowed = '0;
        errCount = 0;
        numChecks = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_invert();
        t_channels();
        t_nonoverlap();
        t_borrow();
        results();
    end

    initial
    begin
        #20000;
        errCount++;
        results();
    end
endmodule : ppo_top_test

bind ppo_top ppo_top_sva SVA (.clk(clk), .nrst(nrst), .busReq(busReq),
    .rdData(rdData), .timerEvt(timerEvt), .pinBorrowed(pinBorrowed),
    .pulseOut(pulseOut), .pulseOutEn(pulseOutEn));
